/* src/cpsw_status.sv */
/*
 * processor status word register with indicator logic, mode protection,
 * save and restore on calls, returns and interrupts.
 * assumes the execution sequencer presents one completing instruction per
 * cycle on the result port and transfer requests one cycle wide.
 */
// Decided for this implementation: the placing of the registers and the strobed register port.
`include "cpsw_consts.svh"
module cpsw_status
  import cpsw_pkg::*;
(
  input  wire logic                     core_clk,    // cpu clock
  input  wire logic                     resetn,      // async reset, low
  input  wire cpsw_pkg::cpsw_result_t   result,      // completing insn
  input  wire cpsw_pkg::cpsw_xfer_req_t xfer,        // call/return/irq
  input  wire logic [3:0]               reg_addr,    // register address
  input  wire logic [15:0]              reg_wdata,   // write data
  input  wire logic                     reg_wr,      // write strobe
  input  wire logic                     reg_rd,      // read strobe
  output logic [15:0]                   reg_rdata,   // read data
  output logic [15:0]                   status_word, // current word
  output logic [15:0]                   saved_out,   // word for marker
  output logic                          priv_mode,   // privileged now
  output logic                          trap_req,    // to segment 17
  output logic                          ret_trap,    // illegal return
  output logic                          mode_fault   // illegal mode change
);
  import cpsw_pkg::*;

  // word bit n sits at vector index 15-n
  function automatic int unsigned ix(input int unsigned pos);
    return 15 - pos;
  endfunction

  function automatic logic [1:0] cmp_code(input logic signed [15:0] a,
                                          input logic signed [15:0] b);
    if (a > b)
      return `CPSW_CC_GREATER;
    else if (a < b)
      return `CPSW_CC_LESS;
    else
      return `CPSW_CC_EQUAL;
  endfunction

  function automatic logic in_rng(input logic [7:0] v,
                                  input logic [7:0] lo,
                                  input logic [7:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  logic [15:0] word_q;
  logic [15:0] word_d;
  logic [15:0] saved_q;
  logic        trap_q;
  logic        ret_trap_q;
  logic        fault_q;
  logic [15:0] rdata_q;
  logic        priv;
  logic [1:0]  cc_new;
  logic        ovf_new;
  logic        bus_wr_word;
  logic [15:0] bus_mask;

  assign priv = word_q[ix(`CPSW_POS_PRIV)];

  always_comb begin
    cc_new = word_q[ix(`CPSW_POS_CC_HI):ix(`CPSW_POS_CC_LO)];
    case (result.cc_sel)
      CPSW_CC_SIGN: cc_new = cmp_code(result.opnd_a, 16'h0000);
      CPSW_CC_CMP:  cc_new = cmp_code(result.opnd_a, result.opnd_b);
      CPSW_CC_CHAR: begin
        if (in_rng(result.byte_val, `CPSW_DIGIT_LO, `CPSW_DIGIT_HI))
          cc_new = `CPSW_CC_GREATER;
        else if (in_rng(result.byte_val, `CPSW_UPPER_LO, `CPSW_UPPER_HI) ||
                 in_rng(result.byte_val, `CPSW_LOWER_LO, `CPSW_LOWER_HI))
          cc_new = `CPSW_CC_EQUAL;
        else
          cc_new = `CPSW_CC_LESS;
      end
      default: ;
    endcase
  end

  always_comb begin
    ovf_new = word_q[ix(`CPSW_POS_OVF)];
    if (result.ovf_event) begin
      if (!word_q[ix(`CPSW_POS_UTRAP)] || result.ovf_int)
        ovf_new = 1'b1;
    end else if (result.cc_sel != CPSW_CC_NONE || result.wr_carry) begin
      ovf_new = 1'b0;
    end
  end

  // bits user mode may touch through the register port
  assign bus_wr_word = reg_wr && (reg_addr == `CPSW_ADDR_WORD);
  always_comb begin
    bus_mask = 16'hffff;
    bus_mask[ix(`CPSW_POS_SEG_LO):ix(`CPSW_POS_SEG_LO)] = 1'b1;
    if (!priv) begin
      bus_mask[ix(`CPSW_POS_PRIV)] = 1'b0;
      bus_mask[ix(`CPSW_POS_EXTIRQ)] = 1'b0;
      bus_mask[ix(`CPSW_POS_RPEND)] = 1'b0;
    end
  end

  always_comb begin
    word_d = word_q;
    if (xfer.kind == CPSW_XFER_RETURN) begin
      word_d = xfer.saved_word;
      word_d[ix(`CPSW_POS_UTRAP)] = word_q[ix(`CPSW_POS_UTRAP)];
      if (!priv)
        word_d[ix(`CPSW_POS_PRIV)] = 1'b0;
      if (xfer.handler_seg)
        word_d[ix(`CPSW_POS_EXTIRQ)] = 1'b0;
    end else if (xfer.kind == CPSW_XFER_CALL) begin
      word_d[ix(`CPSW_POS_SEG_HI):ix(`CPSW_POS_SEG_LO)] = xfer.target_seg;
      word_d[ix(`CPSW_POS_PRIV)] = priv | xfer.target_priv;
      if (xfer.handler_seg)
        word_d[ix(`CPSW_POS_EXTIRQ)] = 1'b0;
    end else if (bus_wr_word) begin
      word_d = (word_q & ~bus_mask) | (reg_wdata & bus_mask);
      if (reg_wdata[ix(`CPSW_POS_CC_HI):ix(`CPSW_POS_CC_LO)] == 2'h3)
        word_d[ix(`CPSW_POS_CC_HI):ix(`CPSW_POS_CC_LO)] =
          word_q[ix(`CPSW_POS_CC_HI):ix(`CPSW_POS_CC_LO)];
    end else if (result.valid) begin
      word_d[ix(`CPSW_POS_CC_HI):ix(`CPSW_POS_CC_LO)] = cc_new;
      word_d[ix(`CPSW_POS_OVF)] = ovf_new;
      if (result.wr_carry)
        word_d[ix(`CPSW_POS_CARRY)] = result.carry;
      word_d[ix(`CPSW_POS_RPEND)] = !result.stack_op_last &&
                                    (result.right_op != `CPSW_NOP_OP);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      word_q <= `CPSW_RESET_WORD;
    else
      word_q <= word_d;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      saved_q <= 16'h0000;
    else if (xfer.kind == CPSW_XFER_CALL)
      saved_q <= word_q;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      trap_q <= 1'b0;
    else
      trap_q <= result.valid && result.ovf_event &&
                word_q[ix(`CPSW_POS_UTRAP)];
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ret_trap_q <= 1'b0;
      fault_q    <= 1'b0;
    end else begin
      ret_trap_q <= (xfer.kind == CPSW_XFER_RETURN) && !priv &&
                    (xfer.saved_word[ix(`CPSW_POS_EXTIRQ)] !=
                     word_q[ix(`CPSW_POS_EXTIRQ)]);
      fault_q    <= (xfer.kind == CPSW_XFER_RETURN) && !priv &&
                    xfer.saved_word[ix(`CPSW_POS_PRIV)];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      rdata_q <= 16'h0000;
    else if (reg_rd) begin
      case (reg_addr)
        `CPSW_ADDR_WORD: rdata_q <= word_q;
        `CPSW_ADDR_TRAP: rdata_q <= saved_q;
        default:         rdata_q <= 16'h0000;
      endcase
    end else
      rdata_q <= 16'h0000;
  end

  assign reg_rdata   = rdata_q;
  assign status_word = word_q;
  assign saved_out   = saved_q;
  assign priv_mode   = priv;
  assign trap_req    = trap_q;
  assign ret_trap    = ret_trap_q;
  assign mode_fault  = fault_q;

  property p_no_cc11;
    @(posedge core_clk) disable iff (!resetn)
      word_q[ix(`CPSW_POS_CC_HI):ix(`CPSW_POS_CC_LO)] != 2'h3;
  endproperty
  a_no_cc11: assert property (p_no_cc11)
    else $error("condition code holds 11");

  property p_user_priv;
    @(posedge core_clk) disable iff (!resetn)
      (!priv && xfer.kind == CPSW_XFER_NONE) |=> !priv;
  endproperty
  a_user_priv: assert property (p_user_priv)
    else $error("user mode gained privilege");

  property p_user_irq;
    @(posedge core_clk) disable iff (!resetn)
      (!priv && xfer.kind == CPSW_XFER_NONE) |=>
        $stable(word_q[ix(`CPSW_POS_EXTIRQ)]);
  endproperty
  a_user_irq: assert property (p_user_irq)
    else $error("user mode changed irq enable");

  property p_ret_utrap;
    @(posedge core_clk) disable iff (!resetn)
      (xfer.kind == CPSW_XFER_RETURN) |=> $stable(word_q[ix(2)]);
  endproperty
  a_ret_utrap: assert property (p_ret_utrap)
    else $error("return altered user trap enable");

  property p_trap;
    @(posedge core_clk) disable iff (!resetn)
      (result.valid && result.ovf_event && word_q[ix(2)]) |=> trap_req;
  endproperty
  a_trap: assert property (p_trap)
    else $error("missing overflow trap");

  property p_ovf_off;
    @(posedge core_clk) disable iff (!resetn)
      (result.valid && result.ovf_event && !word_q[ix(2)] &&
       xfer.kind == CPSW_XFER_NONE && !bus_wr_word) |=>
        word_q[ix(`CPSW_POS_OVF)] && !trap_req;
  endproperty
  a_ovf_off: assert property (p_ovf_off)
    else $error("overflow flag not set");

  property p_call_seg;
    @(posedge core_clk) disable iff (!resetn)
      (xfer.kind == CPSW_XFER_CALL) |=>
        word_q[7:0] == $past(xfer.target_seg) && saved_q == $past(word_q);
  endproperty
  a_call_seg: assert property (p_call_seg)
    else $error("call segment number wrong");

  property p_handler;
    @(posedge core_clk) disable iff (!resetn)
      (xfer.kind != CPSW_XFER_NONE && xfer.handler_seg) |=>
        !word_q[ix(`CPSW_POS_EXTIRQ)];
  endproperty
  a_handler: assert property (p_handler)
    else $error("handler entry left irq enabled");

  property p_cmp;
    @(posedge core_clk) disable iff (!resetn)
      (result.valid && result.cc_sel == CPSW_CC_CMP &&
       xfer.kind == CPSW_XFER_NONE && !bus_wr_word &&
       result.opnd_a == result.opnd_b) |=>
        word_q[ix(`CPSW_POS_CC_HI):ix(`CPSW_POS_CC_LO)] == `CPSW_CC_EQUAL;
  endproperty
  a_cmp: assert property (p_cmp)
    else $error("equal compare not coded equal");

  property p_user_rpend;
    @(posedge core_clk) disable iff (!resetn)
      (!priv && bus_wr_word && xfer.kind == CPSW_XFER_NONE) |=>
        $stable(word_q[ix(`CPSW_POS_RPEND)]);
  endproperty
  a_user_rpend: assert property (p_user_rpend)
    else $error("user write changed right op pending");

  property p_rpend_set;
    @(posedge core_clk) disable iff (!resetn)
      (result.valid && !result.stack_op_last &&
       result.right_op != `CPSW_NOP_OP &&
       xfer.kind == CPSW_XFER_NONE && !bus_wr_word) |=>
        word_q[ix(`CPSW_POS_RPEND)];
  endproperty
  a_rpend_set: assert property (p_rpend_set)
    else $error("right op pending not set");

  property p_carry;
    @(posedge core_clk) disable iff (!resetn)
      (result.valid && result.wr_carry &&
       xfer.kind == CPSW_XFER_NONE && !bus_wr_word) |=>
        word_q[ix(`CPSW_POS_CARRY)] == $past(result.carry);
  endproperty
  a_carry: assert property (p_carry)
    else $error("carry flag not taken from result");

  property p_sign_neg;
    @(posedge core_clk) disable iff (!resetn)
      (result.valid && result.cc_sel == CPSW_CC_SIGN &&
       result.opnd_a[15] &&
       xfer.kind == CPSW_XFER_NONE && !bus_wr_word) |=>
        word_q[ix(`CPSW_POS_CC_HI):ix(`CPSW_POS_CC_LO)] == `CPSW_CC_LESS;
  endproperty
  a_sign_neg: assert property (p_sign_neg)
    else $error("negative operand not coded less");

  property p_char_digit;
    @(posedge core_clk) disable iff (!resetn)
      (result.valid && result.cc_sel == CPSW_CC_CHAR &&
       result.byte_val >= `CPSW_DIGIT_LO &&
       result.byte_val <= `CPSW_DIGIT_HI &&
       xfer.kind == CPSW_XFER_NONE && !bus_wr_word) |=>
        word_q[ix(`CPSW_POS_CC_HI):ix(`CPSW_POS_CC_LO)] == `CPSW_CC_GREATER;
  endproperty
  a_char_digit: assert property (p_char_digit)
    else $error("digit byte not coded greater");

  property p_ret_user;
    @(posedge core_clk) disable iff (!resetn)
      (xfer.kind == CPSW_XFER_RETURN && !priv) |=> !priv;
  endproperty
  a_ret_user: assert property (p_ret_user)
    else $error("user return raised privilege");

  property p_ret_trap;
    @(posedge core_clk) disable iff (!resetn)
      (xfer.kind == CPSW_XFER_RETURN && !priv &&
       xfer.saved_word[ix(`CPSW_POS_EXTIRQ)] !=
       word_q[ix(`CPSW_POS_EXTIRQ)]) |=> ret_trap;
  endproperty
  a_ret_trap: assert property (p_ret_trap)
    else $error("altered irq enable not trapped");

  property p_ret_seg;
    @(posedge core_clk) disable iff (!resetn)
      (xfer.kind == CPSW_XFER_RETURN) |=>
        word_q[7:0] == $past(xfer.saved_word[7:0]);
  endproperty
  a_ret_seg: assert property (p_ret_seg)
    else $error("return did not restore segment");

endmodule

/* src/cpsw_consts.svh */
/*
 * constants for the processor status word block: bit positions, widths,
 * condition-code encodings, character class bounds and local offsets.
 * assumes it is included by bare name from the package and design file.
 */
`ifndef CPSW_CONSTS_SVH
`define CPSW_CONSTS_SVH

`define CPSW_WIDTH        16
// bit numbering: position 0 is the msb of the word
`define CPSW_POS_PRIV     0
`define CPSW_POS_EXTIRQ   1
`define CPSW_POS_UTRAP    2
`define CPSW_POS_RPEND    3
`define CPSW_POS_OVF      4
`define CPSW_POS_CARRY    5
`define CPSW_POS_CC_HI    6
`define CPSW_POS_CC_LO    7
`define CPSW_POS_SEG_HI   8
`define CPSW_POS_SEG_LO   15
`define CPSW_POS_ROP_HI   10
`define CPSW_POS_ROP_LO   15

`define CPSW_CC_GREATER   2'h0
`define CPSW_CC_LESS      2'h1
`define CPSW_CC_EQUAL     2'h2

`define CPSW_DIGIT_LO     8'h30
`define CPSW_DIGIT_HI     8'h39
`define CPSW_UPPER_LO     8'h41
`define CPSW_UPPER_HI     8'h5a
`define CPSW_LOWER_LO     8'h61
`define CPSW_LOWER_HI     8'h7a

`define CPSW_NOP_OP       6'h00
`define CPSW_TRAP_SEG     8'h11
`define CPSW_RESET_WORD   16'h8000

// register port addresses
`define CPSW_ADDR_WORD    4'h0
`define CPSW_ADDR_TRAP    4'h1

`endif

/* src/cpsw_pkg.sv */
/*
 * types for the processor status word block.
 * assumes the constants header is on the include path.
 */
`include "cpsw_consts.svh"

package cpsw_pkg;

  typedef enum logic [1:0] {
    CPSW_CC_NONE,
    CPSW_CC_SIGN,
    CPSW_CC_CHAR,
    CPSW_CC_CMP
  } cpsw_cc_sel_t;

  typedef enum logic [1:0] {
    CPSW_XFER_NONE,
    CPSW_XFER_CALL,
    CPSW_XFER_RETURN
  } cpsw_xfer_t;

  typedef enum {
    CPSW_IDLE,
    CPSW_RESTORED
  } cpsw_state_t;

  // result of one completing instruction (or one stack op)
  typedef struct packed {
    logic          valid;
    logic          stack_op_last;
    cpsw_cc_sel_t  cc_sel;
    logic [15:0]   opnd_a;
    logic [15:0]   opnd_b;
    logic [7:0]    byte_val;
    logic          wr_carry;
    logic          carry;
    logic          ovf_event;
    logic          ovf_int;
    logic [5:0]    right_op;
  } cpsw_result_t;

  // control transfer request from the sequencer
  typedef struct packed {
    cpsw_xfer_t  kind;
    logic [15:0] saved_word;
    logic [7:0]  target_seg;
    logic        target_priv;
    logic        handler_seg;
  } cpsw_xfer_req_t;

endpackage

/* sim/cpsw_seq_model.sv */
/*
 * model of the execution sequencer facing the status word block: it
 * presents one completing instruction or one transfer request per call.
 * assumes the bench calls its tasks and that requests last one cycle.
 */
module cpsw_seq_model (
  input  wire logic                 core_clk, // cpu clock
  output cpsw_pkg::cpsw_result_t    result,   // completing insn
  output cpsw_pkg::cpsw_xfer_req_t  xfer      // call or return
);
  timeunit 1ns;
  timeprecision 1ps;
  import cpsw_pkg::*;

  initial begin
    result = '0;
    xfer   = '0;
  end

  // operands and stack op order come from caller
  task automatic run(input cpsw_result_t r);
    @(posedge core_clk);
    result <= r;
    @(posedge core_clk);
    // released fields show inverted garbage, not the last value
    result <= {1'b0, ~r[$bits(cpsw_result_t)-2:0]};
  endtask

  task automatic go(input cpsw_xfer_t k, input logic [15:0] sw,
                    input logic [7:0] sg, input logic p, input logic h);
    @(posedge core_clk);
    xfer <= '{k, sw, sg, p, h};
    @(posedge core_clk);
    xfer <= '{CPSW_XFER_NONE, ~sw, ~sg, ~p, ~h};
  endtask
endmodule

/* sim/cpsw_status_test.sv */
/*
 * self-checking bench for the status word block: register port tasks,
 * instruction results and transfers through the sequencer model.
 * assumes the package and constants header are compiled first.
 */
`include "cpsw_consts.svh"
module cpsw_status_test;
  timeunit 1ns;
  timeprecision 1ps;
  import cpsw_pkg::*;

  logic                 core_clk, resetn, reg_wr, reg_rd;
  logic [3:0]           reg_addr;
  logic [15:0]          reg_wdata, reg_rdata, status_word, saved_out, w;
  logic                 priv_mode, trap_req, ret_trap, mode_fault;
  cpsw_result_t         result;
  cpsw_xfer_req_t       xfer;
  int                   err_count, checked, i;
  logic [15:0]          sv[5] = '{16'h1, 16'h7fff, 16'h8000, 16'hffff, 16'h0};
  logic [7:0]           cb[12] = '{8'h30, 8'h39, 8'h2f, 8'h3a, 8'h41, 8'h5a,
                                   8'h40, 8'h5b, 8'h61, 8'h7a, 8'h60, 8'h7b};
  logic [31:0]          cp[5] = '{32'h00050003, 32'h00030005, 32'h00070007,
                                  32'hffff0001, 32'h0001ffff};

  cpsw_status cpsw_status_i (.core_clk(core_clk), .resetn(resetn),
    .result(result), .xfer(xfer), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .status_word(status_word),
    .saved_out(saved_out), .priv_mode(priv_mode), .trap_req(trap_req),
    .ret_trap(ret_trap), .mode_fault(mode_fault));
  cpsw_seq_model cpsw_seq_model_i (.core_clk(core_clk), .result(result),
    .xfer(xfer));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [15:0] got, exp, input string m);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic ex(input cpsw_cc_sel_t s, input logic [15:0] a, b,
                    input logic [7:0] y, input logic [4:0] f,
                    input logic [5:0] op);
    // f is {write carry, carry, overflow, integer overflow, last op}
    cpsw_seq_model_i.run('{1'b1, f[0], s, a, b, y, f[4], f[3], f[2],
                           f[1], op});
    #1;
  endtask
  task automatic xf(input cpsw_xfer_t k, input logic [15:0] sw,
                    input logic [7:0] sg, input logic p, h);
    cpsw_seq_model_i.go(k, sw, sg, p, h);
    #1;
  endtask

  function automatic logic [15:0] wd(input logic [15:0] b,
                                     input logic [1:0] c);
    return {b[15:10], c, b[7:0]};
  endfunction
  function automatic logic [1:0] ccs(input logic signed [15:0] a, b);
    return (a > b) ? `CPSW_CC_GREATER : (a < b) ? `CPSW_CC_LESS
                                                : `CPSW_CC_EQUAL;
  endfunction

  function automatic logic [1:0] ccb(input logic [7:0] y);
    if (y >= `CPSW_DIGIT_LO && y <= `CPSW_DIGIT_HI)
      return `CPSW_CC_GREATER;
    if ((y >= `CPSW_UPPER_LO && y <= `CPSW_UPPER_HI) ||
        (y >= `CPSW_LOWER_LO && y <= `CPSW_LOWER_HI))
      return `CPSW_CC_EQUAL;
    return `CPSW_CC_LESS;
  endfunction

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #20us;
    err_count++;
    tally_and_finish();
  end

  initial begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    rd(4'h0, w);
    chk(w, 16'h8000, "reset word");
    chk(16'(priv_mode), 16'h1, "reset mode");
    wr(4'h0, 16'h8005);
    chk(status_word, 16'h8005, "priv write");
    $display("test reset done");
    for (i = 0; i < 5; i++) begin
      ex(CPSW_CC_SIGN, sv[i], 16'h0, 8'h0, 5'h01, 6'h0);
      chk(status_word, wd(16'h8005, ccs(sv[i], 0)), "sign");
    end
    for (i = 0; i < 12; i++) begin
      ex(CPSW_CC_CHAR, 16'h0, 16'h0, cb[i], 5'h01, 6'h0);
      chk(status_word, wd(16'h8005, ccb(cb[i])), "char");
    end
    for (i = 0; i < 5; i++) begin
      ex(CPSW_CC_CMP, cp[i][31:16], cp[i][15:0], 8'h0, 5'h01, 6'h0);
      chk(status_word, wd(16'h8005, ccs(cp[i][31:16], cp[i][15:0])),
          "compare");
    end
    $display("test cond code done");
    ex(CPSW_CC_NONE, 16'h0, 16'h0, 8'h0, 5'h19, 6'h0);
    chk(status_word, 16'h8405, "carry set");
    ex(CPSW_CC_NONE, 16'h0, 16'h0, 8'h0, 5'h11, 6'h0);
    chk(status_word, 16'h8005, "carry clear");
    ex(CPSW_CC_NONE, 16'h0, 16'h0, 8'h0, 5'h05, 6'h0);
    chk(status_word, 16'h8805, "ovf no trap");
    chk(16'(trap_req), 16'h0, "no trap");
    wr(4'h0, 16'ha005);
    ex(CPSW_CC_NONE, 16'h0, 16'h0, 8'h0, 5'h05, 6'h0);
    chk(16'(trap_req), 16'h1, "trap");
    chk(status_word, 16'ha005, "trap no flag");
    ex(CPSW_CC_NONE, 16'h0, 16'h0, 8'h0, 5'h07, 6'h0);
    chk(16'(trap_req), 16'h1, "int trap");
    chk(status_word, 16'ha805, "int flag");
    ex(CPSW_CC_NONE, 16'h0, 16'h0, 8'h0, 5'h10, 6'h05);
    chk(status_word, 16'hb005, "right pend");
    ex(CPSW_CC_NONE, 16'h0, 16'h0, 8'h0, 5'h11, 6'h05);
    chk(status_word, 16'ha005, "last op");
    $display("test indicators done");
    wr(4'h0, 16'ha305);
    chk(status_word, 16'ha005, "cc 11 kept");
    rd(4'h7, w);
    chk(w, 16'h0, "unmapped");
    xf(CPSW_XFER_CALL, 16'h0, 8'h2a, 1'b0, 1'b0);
    chk(status_word, 16'ha02a, "call seg");
    chk(saved_out, 16'ha005, "call save");
    rd(4'h1, w);
    chk(w, 16'ha005, "saved read");
    xf(CPSW_XFER_RETURN, 16'hc033, 8'h0, 1'b0, 1'b1);
    chk(status_word, 16'ha033, "handler ret");
    chk(16'({ret_trap, mode_fault}), 16'h0, "priv ret ok");
    xf(CPSW_XFER_RETURN, 16'h4011, 8'h0, 1'b0, 1'b0);
    chk(status_word, 16'h6011, "to user");
    chk(16'(priv_mode), 16'h0, "user mode");
    wr(4'h0, 16'h9144);
    chk(status_word, 16'h4144, "user write");
    xf(CPSW_XFER_RETURN, 16'h8055, 8'h0, 1'b0, 1'b0);
    chk(16'(ret_trap), 16'h1, "ret trap");
    chk(16'(mode_fault), 16'h1, "mode fault");
    chk(status_word, 16'h0055, "user ret");
    xf(CPSW_XFER_RETURN, 16'h4066, 8'h0, 1'b0, 1'b0);
    chk(16'({ret_trap, mode_fault}), 16'h2, "irq alter");
    xf(CPSW_XFER_CALL, 16'h0, 8'h77, 1'b0, 1'b1);
    chk(status_word, 16'h0077, "call handler");
    chk(saved_out, 16'h4066, "user call save");
    $display("test modes done");
    tally_and_finish();
  end
endmodule
